// *** verilog/flash_protect_params.svh ***
// Constants for the flash block erase and protection logic
`ifndef FLASH_PROTECT_PARAMS_SVH
`define FLASH_PROTECT_PARAMS_SVH
`define FP_WORDS       16'h4000
`define FP_ADDR_W      14
`define FP_UNIT_LSB    8
`define FP_UNIT_MSB    13
`define FP_REGION_LSB  9
`define FP_NUM_UNITS   64
`define FP_NUM_REGIONS 32
`define FP_UNIT_WORDS  9'h100
`define FP_ERASED_WORD 32'hffff_ffff
`define FP_PROT_RESET  2'h0
`endif

// *** verilog/flash_protect_pkg.sv ***
// Types for the flash block erase and protection logic
package flash_protect_pkg;
  typedef logic [13:0] word_addr_t;
  typedef logic [31:0] word_t;
  // Per-region protection attribute
  typedef enum logic [1:0] {
    prot_open = 2'h0,
    prot_read_only = 2'h1,
    prot_exec_only = 2'h2
  } prot_t;
  // Request kinds screened by the checker
  typedef enum logic [1:0] {
    req_fetch = 2'h0,
    req_data_read = 2'h1,
    req_program = 2'h2,
    req_erase = 2'h3
  } req_kind_t;
  typedef enum logic [1:0] {
    st_idle = 2'h0,
    st_erase = 2'h1
  } erase_state_t;
endpackage

// *** verilog/flash_check_if.sv ***
// Request and verdict signals between the array and its protection checker
interface flash_check_if;
  import flash_protect_pkg::*;
  logic [4:0] region;
  req_kind_t  kind;
  prot_t      prot;
  logic       allow;
  modport array_side (output region, output kind, input prot, input allow);
  modport check_side (input region, input kind, output prot, output allow);
endinterface

// *** verilog/flash_region_check.sv ***
// Protection attribute table and access verdict per 2 KB region
`include "flash_protect_params.svh"
module flash_region_check (
  // Clock and reset
  input  wire logic                      ref_clk_in,
  input  wire logic                      resetn_in,
  // Attribute update
  input  wire logic                      prot_wr_in,
  input  wire logic [4:0]                prot_region_in,
  input  wire flash_protect_pkg::prot_t  prot_value_in,
  // Checker port
  flash_check_if.check_side              chk
);
  import flash_protect_pkg::*;

  typedef struct packed {
    prot_t [`FP_NUM_REGIONS-1:0] attr;
  } check_state_t;

  check_state_t state;
  check_state_t next_state;

  // Decide whether a request kind may touch a region of given attribute
  function automatic logic permitted(prot_t p, req_kind_t k);
    unique case (p)
      prot_read_only: permitted = (k == req_fetch) || (k == req_data_read);
      prot_exec_only: permitted = (k == req_fetch);
      default:        permitted = 1'b1;
    endcase
  endfunction

  // Attribute table update, one region at a time
  always_comb begin
    next_state = state;
    if (prot_wr_in) begin
      next_state.attr[prot_region_in] = prot_value_in;
    end
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // Both units of a region share one attribute entry
  assign chk.prot  = state.attr[chk.region];
  assign chk.allow = permitted(state.attr[chk.region], chk.kind);

  a_exec_denies_read: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (chk.prot == prot_exec_only && chk.kind == req_data_read) |-> !chk.allow)
    else $error("data read allowed in execute-only region");
  a_ro_denies_write: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (chk.prot == prot_read_only && (chk.kind == req_program || chk.kind == req_erase)) |-> !chk.allow)
    else $error("write allowed in read-only region");
  a_attr_written: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    prot_wr_in |=> state.attr[$past(prot_region_in)] == $past(prot_value_in))
    else $error("protection attribute not stored");
endmodule // flash_region_check

// *** verilog/flash_block_erase_protect.sv ***
// Flash array with per-block erase and per-region protection screening
// What this block does
// - A 64 KB array is split into 1 KB units, each erased alone without touching the others.
// - A finished erase leaves every bit of its 1 KB unit at one.
// - Protection is held per 2 KB region of two adjacent units, shared by both.
// - Each region can be set on its own to read-only or execute-only.
// - Read-only regions refuse erase and program, keep their contents, and still allow reads.
// - Execute-only regions refuse erase and program and serve only instruction fetches, not data reads.
// - A permitted read returns its word in one clock cycle with no wait states.
`include "flash_protect_params.svh"
module flash_block_erase_protect (
  // Clock and reset
  input  wire logic                         ref_clk_in,
  input  wire logic                         resetn_in,
  // Instruction fetch port
  input  wire logic                         fetch_req_in,
  input  wire flash_protect_pkg::word_addr_t fetch_addr_in,
  output logic                              fetch_valid_out,
  output flash_protect_pkg::word_t          fetch_data_out,
  // Data read port, processor or debugger
  input  wire logic                         read_req_in,
  input  wire logic                         read_debug_in,
  input  wire flash_protect_pkg::word_addr_t read_addr_in,
  output logic                              read_valid_out,
  output logic                              read_denied_out,
  output flash_protect_pkg::word_t          read_data_out,
  // Program and erase port
  input  wire logic                         prog_req_in,
  input  wire flash_protect_pkg::word_addr_t prog_addr_in,
  input  wire flash_protect_pkg::word_t     prog_data_in,
  input  wire logic                         erase_req_in,
  input  wire logic [5:0]                   erase_unit_in,
  output logic                              write_ready_out,
  output logic                              write_done_out,
  output logic                              write_denied_out,
  // Protection attribute update
  input  wire logic                         prot_wr_in,
  input  wire logic [4:0]                   prot_region_in,
  input  wire flash_protect_pkg::prot_t     prot_value_in,
  // Refusal status
  input  wire logic                         fault_clear_in,
  output logic                              fault_out
);
  import flash_protect_pkg::*;

  typedef struct packed {
    erase_state_t state;
    logic [5:0]   erase_unit;
    logic [7:0]   erase_idx;
    logic         fetch_valid;
    word_t        fetch_data;
    logic         read_valid;
    logic         read_denied;
    word_t        read_data;
    logic         write_done;
    logic         write_denied;
    logic         fault;
  } ctrl_t;

  ctrl_t ctrl;
  ctrl_t next_ctrl;
  word_t mem [0:`FP_WORDS-1];

  // Separate checkers for the three request streams
  flash_check_if fetch_chk ();
  flash_check_if read_chk ();
  flash_check_if write_chk ();

  flash_region_check u_fetch_chk (
    .ref_clk_in     (ref_clk_in),
    .resetn_in      (resetn_in),
    .prot_wr_in     (prot_wr_in),
    .prot_region_in (prot_region_in),
    .prot_value_in  (prot_value_in),
    .chk            (fetch_chk.check_side)
  );
  flash_region_check u_read_chk (
    .ref_clk_in     (ref_clk_in),
    .resetn_in      (resetn_in),
    .prot_wr_in     (prot_wr_in),
    .prot_region_in (prot_region_in),
    .prot_value_in  (prot_value_in),
    .chk            (read_chk.check_side)
  );
  flash_region_check u_write_chk (
    .ref_clk_in     (ref_clk_in),
    .resetn_in      (resetn_in),
    .prot_wr_in     (prot_wr_in),
    .prot_region_in (prot_region_in),
    .prot_value_in  (prot_value_in),
    .chk            (write_chk.check_side)
  );

  logic       write_req;
  logic       write_ok;
  logic       refuse;
  word_addr_t erase_addr;

  // Region index is the address above the 2 KB boundary
  assign fetch_chk.region = fetch_addr_in[`FP_UNIT_MSB:`FP_REGION_LSB];
  assign fetch_chk.kind   = req_fetch;
  assign read_chk.region  = read_addr_in[`FP_UNIT_MSB:`FP_REGION_LSB];
  assign read_chk.kind    = req_data_read;
  assign write_chk.region = erase_req_in ? erase_unit_in[5:1] : prog_addr_in[`FP_UNIT_MSB:`FP_REGION_LSB];
  assign write_chk.kind   = erase_req_in ? req_erase : req_program;

  // Writes are held off while an erase sweeps its unit
  assign write_ready_out = (ctrl.state == st_idle);
  assign write_req       = (erase_req_in || prog_req_in) && write_ready_out;
  assign write_ok        = write_req && write_chk.allow;
  assign refuse          = (write_req && !write_chk.allow) || (read_req_in && !read_chk.allow);
  assign erase_addr      = {ctrl.erase_unit, ctrl.erase_idx};

  always_comb begin
    next_ctrl = ctrl;
    next_ctrl.write_done   = 1'b0;
    next_ctrl.write_denied = write_req && !write_chk.allow;
    // Reads answer on the next edge, no wait states
    next_ctrl.fetch_valid  = fetch_req_in;
    next_ctrl.fetch_data   = mem[fetch_addr_in];
    next_ctrl.read_valid   = read_req_in && read_chk.allow;
    next_ctrl.read_denied  = read_req_in && !read_chk.allow;
    next_ctrl.read_data    = read_chk.allow ? mem[read_addr_in] : '0;
    // Set wins over clear so a refusal in the clear cycle is kept
    if (fault_clear_in) begin
      next_ctrl.fault = 1'b0;
    end
    if (refuse) begin
      next_ctrl.fault = 1'b1;
    end
    unique case (ctrl.state)
      st_idle: begin
        if (write_ok && erase_req_in) begin
          next_ctrl.state      = st_erase;
          next_ctrl.erase_unit = erase_unit_in;
          next_ctrl.erase_idx  = '0;
        end else if (write_ok) begin
          next_ctrl.write_done = 1'b1;
        end
      end
      st_erase: begin
        next_ctrl.erase_idx = ctrl.erase_idx + 8'h01;
        if (ctrl.erase_idx == 8'hff) begin
          next_ctrl.state      = st_idle;
          next_ctrl.write_done = 1'b1;
        end
      end
    endcase
    if (read_debug_in && fetch_req_in) begin
      next_ctrl.fetch_valid = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl <= '0;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // Array storage; one word per cycle so an erase takes 256 cycles
  always_ff @(posedge ref_clk_in) begin
    if (ctrl.state == st_erase) begin
      mem[erase_addr] <= `FP_ERASED_WORD;
    end else if (write_ok && !erase_req_in) begin
      mem[prog_addr_in] <= mem[prog_addr_in] & prog_data_in; // Program only clears bits
    end
  end

  assign fetch_valid_out  = ctrl.fetch_valid;
  assign fetch_data_out   = ctrl.fetch_data;
  assign read_valid_out   = ctrl.read_valid;
  assign read_denied_out  = ctrl.read_denied;
  assign read_data_out    = ctrl.read_data;
  assign write_done_out   = ctrl.write_done;
  assign write_denied_out = ctrl.write_denied;
  assign fault_out        = ctrl.fault;

  sequence s_erase_start;
    ctrl.state == st_idle && write_ok && erase_req_in;
  endsequence
  // The last word is erased on the 256th edge after the request, so done is sampled on the 257th
  sequence s_erase_end;
    ##257 write_done_out;
  endsequence

  a_erase_length: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    s_erase_start |-> s_erase_end)
    else $error("erase did not finish in 257 cycles");
  a_read_latency: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (read_req_in && read_chk.allow) |=> read_valid_out)
    else $error("permitted read not answered next cycle");
  a_denied_read_data: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    read_denied_out |-> (read_data_out == '0 && !read_valid_out))
    else $error("denied read returned data");
  a_fault_sticky: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    refuse |=> fault_out)
    else $error("refusal not flagged");
  a_refused_no_done: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (write_req && !write_chk.allow) |=> (write_denied_out && !write_done_out))
    else $error("refused write reported done");
  // The unit must not move mid-sweep, or a neighbour would be partly wiped
  a_erase_in_unit: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (ctrl.state == st_erase && ctrl.erase_idx != 8'hff) |=> (ctrl.state == st_erase &&
      ctrl.erase_unit == $past(ctrl.erase_unit) && ctrl.erase_idx == $past(ctrl.erase_idx) + 8'h01))
    else $error("erase strayed outside its unit");

  // Fetch answers and status flag behaviour
  a_fetch_latency: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    fetch_req_in |=> fetch_valid_out)
    else $error("fetch not answered next cycle");
  a_fault_clear: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (fault_clear_in && !refuse) |=> !fault_out)
    else $error("fault flag not cleared");
  a_fault_hold: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (fault_out && !fault_clear_in) |=> fault_out)
    else $error("fault flag dropped without a clear");
  a_no_early_done: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (ctrl.state == st_erase) |-> !write_done_out)
    else $error("erase reported done before its sweep ended");
endmodule // flash_block_erase_protect

// *** testbench/flash_req_model.sv ***
// Processor, debugger and loader requests toward the flash block
module flash_req_model
  import flash_protect_pkg::*;
(
  // Clock
  input  wire logic ref_clk_in,
  // Requests toward the array, all driven at the falling edge
  output logic       fetch_req_out   = 1'b0,
  output word_addr_t fetch_addr_out  = '0,
  output logic       read_req_out    = 1'b0,
  output logic       read_debug_out  = 1'b0,
  output word_addr_t read_addr_out   = '0,
  output logic       prog_req_out    = 1'b0,
  output word_addr_t prog_addr_out   = '0,
  output word_t      prog_data_out   = '0,
  output logic       erase_req_out   = 1'b0,
  output logic [5:0] erase_unit_out  = '0,
  output logic       prot_wr_out     = 1'b0,
  output logic [4:0] prot_region_out = '0,
  output prot_t      prot_value_out  = prot_open,
  output logic       fault_clear_out = 1'b0
);
  // Each request lasts one cycle; released fetch, read, program and erase buses are inverted so a stale
  // address can never pass for a held one
  task automatic fetch(input word_addr_t a);
    @(negedge ref_clk_in);
    fetch_req_out = 1'b1;
    fetch_addr_out = a;
    @(negedge ref_clk_in);
    fetch_req_out = 1'b0;
    fetch_addr_out = ~a;
  endtask
  task automatic read(input word_addr_t a, input logic dbg);
    @(negedge ref_clk_in);
    read_req_out = 1'b1;
    read_debug_out = dbg;
    read_addr_out = a;
    @(negedge ref_clk_in);
    read_req_out = 1'b0;
    read_addr_out = ~a;
  endtask
  task automatic prog(input word_addr_t a, input word_t d);
    @(negedge ref_clk_in);
    prog_req_out = 1'b1;
    prog_addr_out = a;
    prog_data_out = d;
    @(negedge ref_clk_in);
    prog_req_out = 1'b0;
    prog_addr_out = ~a;
    prog_data_out = ~d;
  endtask
  task automatic erase(input logic [5:0] u);
    @(negedge ref_clk_in);
    erase_req_out = 1'b1;
    erase_unit_out = u;
    @(negedge ref_clk_in);
    erase_req_out = 1'b0;
    erase_unit_out = ~u;
  endtask
  task automatic set_prot(input logic [4:0] r, input prot_t v);
    @(negedge ref_clk_in);
    prot_wr_out = 1'b1;
    prot_region_out = r;
    prot_value_out = v;
    @(negedge ref_clk_in);
    prot_wr_out = 1'b0;
  endtask
  task automatic clear_fault();
    @(negedge ref_clk_in);
    fault_clear_out = 1'b1;
    @(negedge ref_clk_in);
    fault_clear_out = 1'b0;
  endtask
endmodule // flash_req_model

// *** testbench/tb_top.sv ***
// Self-checking bench for the flash block erase and protection logic
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import flash_protect_pkg::*;
  logic ref_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic fetch_req_in, read_req_in, read_debug_in, prog_req_in, erase_req_in, prot_wr_in, fault_clear_in;
  word_addr_t fetch_addr_in, read_addr_in, prog_addr_in;
  word_t prog_data_in, fetch_data_out, read_data_out;
  logic [5:0] erase_unit_in;
  logic [4:0] prot_region_in;
  prot_t prot_value_in;
  logic fetch_valid_out, read_valid_out, read_denied_out, write_ready_out, write_done_out, write_denied_out;
  logic fault_out;
  int fail_count = 0;
  int n_tests = 0;
  int n;
  // 50 MHz system clock
  always #10 ref_clk_in = ~ref_clk_in;
  flash_block_erase_protect i_dut (.ref_clk_in, .resetn_in, .fetch_req_in, .fetch_addr_in, .fetch_valid_out,
    .fetch_data_out, .read_req_in, .read_debug_in, .read_addr_in, .read_valid_out, .read_denied_out,
    .read_data_out, .prog_req_in, .prog_addr_in, .prog_data_in, .erase_req_in, .erase_unit_in,
    .write_ready_out, .write_done_out, .write_denied_out, .prot_wr_in, .prot_region_in, .prot_value_in,
    .fault_clear_in, .fault_out);
  flash_req_model i_host (.ref_clk_in, .fetch_req_out(fetch_req_in), .fetch_addr_out(fetch_addr_in),
    .read_req_out(read_req_in), .read_debug_out(read_debug_in), .read_addr_out(read_addr_in),
    .prog_req_out(prog_req_in), .prog_addr_out(prog_addr_in), .prog_data_out(prog_data_in),
    .erase_req_out(erase_req_in), .erase_unit_out(erase_unit_in), .prot_wr_out(prot_wr_in),
    .prot_region_out(prot_region_in), .prot_value_out(prot_value_in), .fault_clear_out(fault_clear_in));
  // Comparisons, counted; single-bit flags widen so an unknown still fails
  task automatic chk_word(input word_t got, input word_t exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask
  task automatic end_sim();
    $display("mismatches=%0d compares=%0d", fail_count, n_tests);
    if (fail_count == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Helpers: the answer pulse is present at the falling edge the request ends on
  task automatic rd(input word_addr_t a, input logic dbg, input logic ok, input word_t d);
    i_host.read(a, dbg);
    chk_bit(read_valid_out, ok);
    chk_bit(read_denied_out, !ok);
    chk_word(read_data_out, d);
  endtask
  task automatic wr(input word_addr_t a, input word_t d, input logic ok);
    i_host.prog(a, d);
    chk_bit(write_done_out, ok);
    chk_bit(write_denied_out, !ok);
  endtask
  task automatic erase_wait(input logic [5:0] u);
    i_host.erase(u);
    chk_bit(write_ready_out, 1'b0);
    n = 0;
    while (write_done_out !== 1'b1 && n < 400) begin
      @(negedge ref_clk_in);
      n++;
    end
    // The loop starts one edge after the request edge was taken
    chk_word(32'(n + 1), 32'd257);
  endtask
  // Erase one unit, leave its neighbour alone
  task automatic t_erase_keep();
    chk_bit(write_ready_out, 1'b1);
    chk_bit(fault_out, 1'b0);
    erase_wait(6'h03);
    wr(14'h0300, 32'h1234_5678, 1'b1);
    erase_wait(6'h02);
    rd(14'h0200, 1'b0, 1'b1, 32'hffff_ffff);
    rd(14'h02ff, 1'b0, 1'b1, 32'hffff_ffff);
    rd(14'h0300, 1'b0, 1'b1, 32'h1234_5678);
    rd(14'h0300, 1'b1, 1'b1, 32'h1234_5678);
  endtask
  // Read-only region refuses writes, keeps contents, still serves reads
  task automatic t_read_only();
    i_host.set_prot(5'h01, prot_read_only);
    wr(14'h0300, 32'h0000_0000, 1'b0);
    chk_bit(fault_out, 1'b1);
    i_host.clear_fault();
    chk_bit(fault_out, 1'b0);
    i_host.erase(6'h02);
    chk_bit(write_denied_out, 1'b1);
    rd(14'h0200, 1'b0, 1'b1, 32'hffff_ffff);
    rd(14'h0300, 1'b1, 1'b1, 32'h1234_5678);
    wr(14'h0400, 32'h0000_ffff, 1'b1);
    i_host.clear_fault();
  endtask
  // Execute-only region serves instruction fetches only
  task automatic t_exec_only();
    i_host.set_prot(5'h01, prot_exec_only);
    rd(14'h0300, 1'b0, 1'b0, 32'h0000_0000);
    chk_bit(fault_out, 1'b1);
    rd(14'h0200, 1'b1, 1'b0, 32'h0000_0000);
    i_host.fetch(14'h0300);
    chk_bit(fetch_valid_out, 1'b1);
    chk_word(fetch_data_out, 32'h1234_5678);
    wr(14'h02ff, 32'h0000_0000, 1'b0);
    i_host.erase(6'h03);
    chk_bit(write_denied_out, 1'b1);
    i_host.set_prot(5'h01, prot_open);
    rd(14'h0300, 1'b0, 1'b1, 32'h1234_5678);
  endtask
  // Main sequence
  initial begin
    repeat (6) @(negedge ref_clk_in);
    resetn_in = 1'b1;
    t_erase_keep();
    t_read_only();
    t_exec_only();
    end_sim();
  end
  // Watchdog: the run needs about 570 cycles
  initial begin
    #(20 * 5000);
    fail_count++;
    end_sim();
  end
endmodule // tb_top
